// ==== sas_adc_sequencer.sv ====
// Top: APB registers, interrupts, pins and SAR converter control
//
// Functional notes
// - Result register is read-only to software
// - Control bits 2..0 choose the analog channel
// - Writing zero to bit 3 starts conversion
// - Completion flag low during, high after conversion
// - Control bit 4 connects the reference ladder
// - Eight-bit code drives 256-step ladder
// - Completion and request flag rise together
// - Start never clears the request flag
// - Polarity bit 7 routes completion to shared request
// - Result cleared to zero at start
// - Top bit trial, kept when reference below input
// - Conversion ends within fifty machine cycles
// - Unselected pins stay general-purpose I/O
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
module sas_adc_sequencer (
   input  wire logic        I_REF_CLK,
   input  wire logic        I_NRST,
   input  wire logic        I_PSEL,
   input  wire logic        I_PENABLE,
   input  wire logic        I_PWRITE,
   input  wire logic [7:0]  I_PADDR,
   input  wire logic [31:0] I_PWDATA,
   output logic      [31:0] O_PRDATA,
   output logic             O_PREADY,
   output logic             O_PSLVERR,
   input  wire logic        I_CMP_ABOVE,
   output logic      [7:0]  O_TRIAL_CODE,
   output logic      [2:0]  O_CHAN_SEL,
   output logic             O_LADDER_EN,
   input  wire logic        I_SHARED_EXTERNAL_IRQ_THREE,
   output logic             O_IRQ,
   input  wire logic [7:0]  I_GPIO_IN,
   output logic      [7:0]  O_GPIO_OUT,
   output logic      [7:0]  O_GPIO_OE
);
   import sas_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Address decode
   function automatic logic hit(input logic [7:0] a,
                                input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   ////////////////////////////////////////////////////////////////////////
   // Declarations
   sas_ctrl_t        ctrl_q;
   sas_ctrl_t        ctrl_d;
   logic [IRQ_W-1:0] stat_q;
   logic [IRQ_W-1:0] stat_d;
   logic [IRQ_W-1:0] mask_q;
   logic [IRQ_W-1:0] mask_d;
   logic [7:0]       pol_q;
   logic [7:0]       pol_d;
   logic [7:0]       gout_q;
   logic [7:0]       gout_d;
   logic [7:0]       gdir_q;
   logic [7:0]       gdir_d;
   logic [31:0]      rdata_q;
   logic [31:0]      rdata_d;
   logic             ready_q;
   logic             err_q;
   logic             err_d;
   logic [IRQ_W-1:0] rclr_q;
   logic [IRQ_W-1:0] rclr_d;
   logic             irq_q;
   logic [9:0]       sync1_q;
   logic [9:0]       sync2_q;
   logic             ext_prev_q;
   logic [7:0]       oe_q;
   sas_sar_t         sar;

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         sync1_q <= 10'h000;
         sync2_q <= 10'h000;
      end else begin
         sync1_q <= {I_SHARED_EXTERNAL_IRQ_THREE, I_CMP_ABOVE, I_GPIO_IN};
         sync2_q <= sync1_q;
      end
   end

   wire [7:0] gpio_in_s = sync2_q[7:0];
   wire       cmp_s     = sync2_q[8];
   wire       ext_s     = sync2_q[9];

   always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
      if (!I_NRST)
         ext_prev_q <= 1'b0;
      else
         ext_prev_q <= ext_s;
   end

   // Edge sense chosen by polarity bit 0
   wire ext_rise  = ext_s & ~ext_prev_q;
   wire ext_fall  = ~ext_s & ext_prev_q;
   wire ext_event = pol_q[POL_EDGE_BIT] ? ext_fall : ext_rise;

   ////////////////////////////////////////////////////////////////////////
   // APB phases
   wire setup   = I_PSEL & ~I_PENABLE;
   wire access  = I_PSEL & I_PENABLE & ready_q;
   wire wr_acc  = access & I_PWRITE;
   wire rd_acc  = access & ~I_PWRITE;

   wire sel_res  = hit(I_PADDR, OFS_RESULT);
   wire sel_ctl  = hit(I_PADDR, OFS_CONTROL);
   wire sel_stat = hit(I_PADDR, OFS_IRQ_STAT);
   wire sel_mask = hit(I_PADDR, OFS_IRQ_MASK);
   wire sel_pol  = hit(I_PADDR, OFS_POLARITY);
   wire sel_gout = hit(I_PADDR, OFS_GPIO_OUT);
   wire sel_gdir = hit(I_PADDR, OFS_GPIO_DIR);
   wire sel_gin  = hit(I_PADDR, OFS_GPIO_IN);
   wire mapped   = sel_res | sel_ctl | sel_stat | sel_mask |
                   sel_pol | sel_gout | sel_gdir | sel_gin;

   ////////////////////////////////////////////////////////////////////////
   // Conversion start and completion
   wire wr_ctl = wr_acc & sel_ctl;
   wire start  = wr_ctl & ~I_PWDATA[CTRL_DONE_BIT];

   sas_sar_core u_core (
      .i_clk       (I_REF_CLK),
      .i_nrst      (I_NRST),
      .i_start     (start),
      .i_cmp_above (cmp_s),
      .o_sar       (sar)
   );

   // Control register; completion flag written only by hardware
   always_comb begin
      ctrl_d = ctrl_q;
      if (wr_ctl) begin
         ctrl_d.chan   = I_PWDATA[CTRL_CHAN_MSB:CTRL_CHAN_LSB];
         ctrl_d.ladder = I_PWDATA[CTRL_LADDER_BIT];
      end
      if (start)
         ctrl_d.done = 1'b0;
      else if (sar.done)
         ctrl_d.done = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt status: sticky, cleared by read, set wins over clear
   wire conv_to_req = pol_q[POL_SRC_BIT];
   wire req_set     = conv_to_req ? sar.done : ext_event;
   wire [IRQ_W-1:0] stat_set;

   assign stat_set[IRQ_REQ_BIT]  = req_set;
   assign stat_set[IRQ_CONV_BIT] = sar.done;
   assign stat_set[IRQ_EXT_BIT]  = ext_event;

   // No clear term from start: only a read clears the request
   always_comb begin
      stat_d = stat_q;
      if (rd_acc && sel_stat)
         stat_d = stat_q & ~rclr_q;
      stat_d = stat_d | stat_set;
   end

   ////////////////////////////////////////////////////////////////////////
   // Writable configuration registers
   always_comb begin
      mask_d = mask_q;
      pol_d  = pol_q;
      gout_d = gout_q;
      gdir_d = gdir_q;
      if (wr_acc && sel_mask)
         mask_d = I_PWDATA[IRQ_W-1:0];
      if (wr_acc && sel_pol) begin
         pol_d                = 8'h00;
         pol_d[POL_SRC_BIT]  = I_PWDATA[POL_SRC_BIT];
         pol_d[POL_EDGE_BIT] = I_PWDATA[POL_EDGE_BIT];
      end
      if (wr_acc && sel_gout)
         gout_d = I_PWDATA[7:0];
      if (wr_acc && sel_gdir)
         gdir_d = I_PWDATA[7:0];
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data, captured in the setup cycle
   wire [31:0] rd_res  = {24'h000000, sar.result};
   wire [31:0] rd_ctl  = {27'h0, ctrl_q};
   wire [31:0] rd_stat = {29'h0, stat_q};
   wire [31:0] rd_mask = {29'h0, mask_q};
   wire [31:0] rd_pol  = {24'h000000, pol_q};
   wire [31:0] rd_gout = {24'h000000, gout_q};
   wire [31:0] rd_gdir = {24'h000000, gdir_q};
   wire [31:0] rd_gin  = {24'h000000, gpio_in_s};

   assign rdata_d = sel_res  ? rd_res  :
                    sel_ctl  ? rd_ctl  :
                    sel_stat ? rd_stat :
                    sel_mask ? rd_mask :
                    sel_pol  ? rd_pol  :
                    sel_gout ? rd_gout :
                    sel_gdir ? rd_gdir :
                    sel_gin  ? rd_gin  : 32'h00000000;

   assign err_d  = ~mapped;
   assign rclr_d = stat_q;

   ////////////////////////////////////////////////////////////////////////
   // Bus slave flops
   always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         rdata_q <= 32'h00000000;
         ready_q <= 1'b0;
         err_q   <= 1'b0;
         rclr_q  <= '0;
      end else begin
         ready_q <= setup;
         if (setup) begin
            rdata_q <= I_PWRITE ? 32'h00000000 : rdata_d;
            err_q   <= err_d;
            rclr_q  <= rclr_d;
         end else if (access) begin
            rdata_q <= 32'h00000000;
            err_q   <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register flops
   always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         ctrl_q <= RST_CONTROL[4:0];
         stat_q <= '0;
         mask_q <= RST_IRQ_MASK;
         pol_q  <= RST_POLARITY;
         gout_q <= RST_GPIO;
         gdir_q <= RST_GPIO;
      end else begin
         ctrl_q <= ctrl_d;
         stat_q <= stat_d;
         mask_q <= mask_d;
         pol_q  <= pol_d;
         gout_q <= gout_d;
         gdir_q <= gdir_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt output, level while an unmasked bit stands
   always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
      if (!I_NRST)
         irq_q <= 1'b0;
      else
         irq_q <= |(stat_d & mask_d);
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin drivers: the selected channel's pin is released while the ladder is enabled, others are I/O
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_pin
         wire analog_pin = ctrl_d.ladder &&
                           (ctrl_d.chan == 3'(g));
         always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
            if (!I_NRST)
               oe_q[g] <= 1'b0;
            else
               oe_q[g] <= gdir_d[g] & ~analog_pin;
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   assign O_PRDATA     = rdata_q;
   assign O_PREADY     = ready_q;
   assign O_PSLVERR    = err_q;
   assign O_TRIAL_CODE = sar.result;
   assign O_CHAN_SEL   = ctrl_q.chan;
   assign O_LADDER_EN  = ctrl_q.ladder;
   assign O_IRQ        = irq_q;
   assign O_GPIO_OUT   = gout_q;
   assign O_GPIO_OE    = oe_q;

endmodule : sas_adc_sequencer

// ==== sas_pkg.sv ====
// Package: register map, field layout, reset values and timing
package sas_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register byte offsets on the APB slave
   localparam logic [7:0] OFS_RESULT   = 8'h00;
   localparam logic [7:0] OFS_CONTROL  = 8'h04;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
   localparam logic [7:0] OFS_POLARITY = 8'h10;
   localparam logic [7:0] OFS_GPIO_OUT = 8'h14;
   localparam logic [7:0] OFS_GPIO_DIR = 8'h18;
   localparam logic [7:0] OFS_GPIO_IN  = 8'h1C;

   ////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int unsigned CTRL_CHAN_LSB   = 0;
   localparam int unsigned CTRL_CHAN_MSB   = 2;
   localparam int unsigned CTRL_DONE_BIT   = 3;
   localparam int unsigned CTRL_LADDER_BIT = 4;
   localparam int unsigned POL_EDGE_BIT    = 0;
   localparam int unsigned POL_SRC_BIT     = 7;
   localparam int unsigned IRQ_REQ_BIT     = 0;
   localparam int unsigned IRQ_CONV_BIT    = 1;
   localparam int unsigned IRQ_EXT_BIT     = 2;
   localparam int unsigned IRQ_W           = 3;

   ////////////////////////////////////////////////////////////////////////
   // Reset values
   localparam logic [7:0]       RST_CONTROL  = 8'h08;
   localparam logic [IRQ_W-1:0] RST_IRQ_MASK = 3'h0;
   localparam logic [7:0]       RST_POLARITY = 8'h00;
   localparam logic [7:0]       RST_GPIO     = 8'h00;

   ////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int unsigned CLK_NS      = 10;
   localparam int unsigned MC_NS       = 250;
   localparam int unsigned MC_CYC      = MC_NS / CLK_NS;
   localparam int unsigned MAX_CONV_MC = 50;
   localparam int unsigned MC_W        = 5;
   localparam logic [MC_W-1:0] MC_LAST = MC_W'(MC_CYC - 1);

   ////////////////////////////////////////////////////////////////////////
   // Types
   typedef enum logic [1:0] {
      ST_IDLE   = 2'b00,
      ST_CLEAR  = 2'b01,
      ST_TRIAL  = 2'b10,
      ST_DECIDE = 2'b11
   } sas_state_t;

   typedef struct packed {
      logic       busy;
      logic       done;
      logic [7:0] result;
   } sas_sar_t;

   typedef struct packed {
      logic       ladder;
      logic       done;
      logic [2:0] chan;
   } sas_ctrl_t;

endpackage : sas_pkg

// ==== sas_sar_core.sv ====
// Successive-approximation step engine on machine-cycle ticks
`timescale 1ns/1ns
module sas_sar_core (
   input  wire logic           i_clk,
   input  wire logic           i_nrst,
   input  wire logic           i_start,
   input  wire logic           i_cmp_above,
   output sas_pkg::sas_sar_t   o_sar
);
   import sas_pkg::*;

   sas_state_t      state_q;
   sas_state_t      state_d;
   logic [2:0]      bit_q;
   logic [2:0]      bit_d;
   logic [7:0]      res_q;
   logic [7:0]      res_d;
   logic [MC_W-1:0] mc_q;
   logic            done_q;
   logic            done_d;
   wire             tick = (mc_q == MC_LAST);

   ////////////////////////////////////////////////////////////////////////
   // Machine-cycle enable, realigned at each start
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst)
         mc_q <= '0;
      else if (i_start || tick)
         mc_q <= '0;
      else
         mc_q <= mc_q + 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////
   // Approximation sequence
   always_comb begin
      state_d = state_q;
      bit_d   = bit_q;
      res_d   = res_q;
      done_d  = 1'b0;
      if (i_start) begin
         state_d = ST_CLEAR;
         bit_d   = 3'h7;
         res_d   = 8'h00;
      end else if (tick) begin
         case (state_q)
            ST_CLEAR: begin
               res_d[bit_q] = 1'b1;
               state_d      = ST_TRIAL;
            end
            ST_TRIAL: begin
               state_d = ST_DECIDE;
            end
            ST_DECIDE: begin
               res_d[bit_q] = i_cmp_above;
               if (bit_q == 3'h0) begin
                  state_d = ST_IDLE;
                  done_d  = 1'b1;
               end else begin
                  bit_d        = bit_q - 1'b1;
                  res_d[bit_d] = 1'b1;
                  state_d      = ST_TRIAL;
               end
            end
            default: state_d = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         state_q <= ST_IDLE;
         bit_q   <= 3'h7;
         res_q   <= 8'h00;
         done_q  <= 1'b0;
      end else begin
         state_q <= state_d;
         bit_q   <= bit_d;
         res_q   <= res_d;
         done_q  <= done_d;
      end
   end

   assign o_sar.busy   = (state_q != ST_IDLE);
   assign o_sar.done   = done_q;
   assign o_sar.result = res_q;

endmodule : sas_sar_core

// ==== sas_adc_monitor.sv ====
// Checker: port-level properties of the converter sequencer
`timescale 1ns/1ns
module sas_adc_monitor
   import sas_pkg::*;
(
   input wire logic        I_REF_CLK,
   input wire logic        I_NRST,
   input wire logic        I_PSEL,
   input wire logic        I_PENABLE,
   input wire logic        I_PWRITE,
   input wire logic [7:0]  I_PADDR,
   input wire logic [31:0] I_PWDATA,
   input wire logic [31:0] O_PRDATA,
   input wire logic        O_PREADY,
   input wire logic        O_PSLVERR,
   input wire logic [7:0]  O_TRIAL_CODE,
   input wire logic [2:0]  O_CHAN_SEL,
   input wire logic        O_LADDER_EN,
   input wire logic [7:0]  O_GPIO_OE
);
   logic        acc;
   logic        wr_ctl;
   logic        rd_ctl;
   logic        start;
   logic        chg;
   logic [10:0] since_q;
   logic [4:0]  gap_q;
   logic [7:0]  code_q;
   assign acc    = I_PSEL & I_PENABLE & O_PREADY;
   assign wr_ctl = acc & I_PWRITE & (I_PADDR == OFS_CONTROL);
   assign rd_ctl = acc & ~I_PWRITE & (I_PADDR == OFS_CONTROL);
   assign start  = wr_ctl & ~I_PWDATA[3];
   assign chg    = (code_q != O_TRIAL_CODE);
   // Cycles since last start and since last code change, saturating
   always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         since_q <= 11'h7FF;
         gap_q   <= 5'h1F;
         code_q  <= 8'h00;
      end else begin
         since_q <= start ? 11'h000 : since_q + 11'(since_q != 11'h7FF);
         gap_q   <= chg ? 5'h00 : gap_q + 5'(gap_q != 5'h1F);
         code_q  <= O_TRIAL_CODE;
      end
   end
   default clocking @(posedge I_REF_CLK); endclocking
   default disable iff (!I_NRST);
   ////////////////////////////////////////////////////////////////////////
   property p_chan;
      wr_ctl |-> ##2 O_CHAN_SEL == $past(I_PWDATA[2:0], 2);
   endproperty
   a_chan: assert property (p_chan)
      else $error("channel select differs from control write");
   property p_ladder;
      wr_ctl |-> ##2 O_LADDER_EN == $past(I_PWDATA[4], 2);
   endproperty
   a_ladder: assert property (p_ladder)
      else $error("ladder enable differs from control write");
   property p_clear;
      start |-> ##2 O_TRIAL_CODE == 8'h00;
   endproperty
   a_clear: assert property (p_clear)
      else $error("code not cleared at start");
   property p_trial;
      start |-> ##27 O_TRIAL_CODE == 8'h80;
   endproperty
   a_trial: assert property (p_trial)
      else $error("top bit trial missing");
   property p_busy;
      rd_ctl && since_q < 11'd400 |-> !O_PRDATA[3];
   endproperty
   a_busy: assert property (p_busy)
      else $error("done flag high during conversion");
   property p_done;
      rd_ctl && since_q > 11'd1250 |-> O_PRDATA[3];
   endproperty
   a_done: assert property (p_done)
      else $error("done flag low after fifty machine cycles");
   property p_step;
      chg && since_q > 11'd3 |-> gap_q >= 5'd20;
   endproperty
   a_step: assert property (p_step)
      else $error("trial code stepped off machine cycle");
   property p_oe;
      acc && I_PWRITE && I_PADDR == OFS_GPIO_DIR
         |-> ##2 (O_LADDER_EN || O_GPIO_OE == $past(I_PWDATA[7:0], 2));
   endproperty
   a_oe: assert property (p_oe)
      else $error("pin direction differs from write");
   property p_err;
      acc && I_PADDR > OFS_GPIO_IN |-> O_PSLVERR && O_PRDATA == 32'h0;
   endproperty
   a_err: assert property (p_err)
      else $error("unmapped access not refused");
endmodule : sas_adc_monitor

bind sas_adc_sequencer sas_adc_monitor mon_u (.I_REF_CLK, .I_NRST,
   .I_PSEL, .I_PENABLE, .I_PWRITE, .I_PADDR, .I_PWDATA, .O_PRDATA,
   .O_PREADY, .O_PSLVERR, .O_TRIAL_CODE, .O_CHAN_SEL, .O_LADDER_EN,
   .O_GPIO_OE);

// ==== sas_cmp_model.sv ====
// Analog side: channel levels, resistor ladder and comparator
`timescale 1ns/1ns
module sas_cmp_model (
   input  wire logic        clk,
   input  wire logic [7:0]  trial_code,
   input  wire logic [2:0]  chan_sel,
   input  wire logic        ladder_en,
   input  wire logic [63:0] levels,
   output logic             cmp_above
);
   logic toggle_q = 1'b0;
   always @(posedge clk) toggle_q <= ~toggle_q;
   // Ladder level is code/256 of supply against the selected input
   // Unpowered ladder gives a meaningless, changing answer
   assign cmp_above = ladder_en ? (trial_code < levels[chan_sel*8 +: 8])
                                : toggle_q;
endmodule : sas_cmp_model

// ==== tb_sar_adc_sequencer.sv ====
// Self-checking bench for the converter sequencer
`timescale 1ns/1ns
module tb_sar_adc_sequencer;
   import sas_pkg::*;
   logic        clk    = 1'b0;
   logic        nrst   = 1'b0;
   logic        psel   = 1'b0;
   logic        pen    = 1'b0;
   logic        pwr    = 1'b0;
   logic        ext    = 1'b0;
   logic [7:0]  paddr  = 8'h00;
   logic [7:0]  gin    = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [63:0] levels = 64'h0;
   logic [31:0] prdata, rd;
   logic [7:0]  code, gout, goe;
   logic [2:0]  chan;
   logic        pready, pslverr, cmp, ladder, irq, err;
   int          fails = 0;
   int          check_count = 0;
   int          lvl [8];
   always #5 clk = ~clk;
   sas_adc_sequencer dut_u (.I_REF_CLK(clk), .I_NRST(nrst), .I_PSEL(psel),
      .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata),
      .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
      .I_CMP_ABOVE(cmp), .O_TRIAL_CODE(code), .O_CHAN_SEL(chan),
      .O_LADDER_EN(ladder), .I_SHARED_EXTERNAL_IRQ_THREE(ext), .O_IRQ(irq),
      .I_GPIO_IN(gin), .O_GPIO_OUT(gout), .O_GPIO_OE(goe));
   sas_cmp_model model_u (.clk(clk), .trial_code(code), .chan_sel(chan),
      .ladder_en(ladder), .levels(levels), .cmp_above(cmp));
   ////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      $display("Checks %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      logic ok;
      ok = 1'b0;
      @(posedge clk);
      psel   <= 1'b1;
      pen    <= 1'b0;
      pwr    <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      // Sample what stands at the coming edge; that edge takes the answer
      while (!ok) begin
         @(negedge clk);
         ok  = (pready === 1'b1);
         rd  = prdata;
         err = pslverr;
         @(posedge clk);
      end
      psel <= 1'b0;
      pen  <= 1'b0;
      @(negedge clk);
   endtask : apb
   // Reference approximation: keep each trial bit while code < level
   function automatic logic [31:0] sar(input int v);
      int r;
      r = 0;
      for (int b = 7; b >= 0; b--) begin
         r = r | (1 << b);
         if (!(r < v)) r = r & ~(1 << b);
      end
      return 32'(r);
   endfunction : sar
   task automatic conv(input int c);
      int k;
      k = 0;
      apb(1'b1, OFS_CONTROL, 32'h18 | 32'(c));
      apb(1'b1, OFS_CONTROL, 32'h10 | 32'(c));
      apb(1'b0, OFS_CONTROL, 32'h0);
      chk(rd, 32'h10 | 32'(c));
      do begin
         apb(1'b0, OFS_CONTROL, 32'h0);
         k++;
      end while (rd[3] !== 1'b1 && k < 500);
      chk(rd, 32'h18 | 32'(c));
      apb(1'b1, OFS_CONTROL, 32'h08 | 32'(c));
      apb(1'b0, OFS_RESULT, 32'h0);
      chk(rd, sar(lvl[c]));
   endtask : conv
   ////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(69453));
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      apb(1'b0, OFS_CONTROL, 32'h0);
      chk(rd, 32'h08);
      apb(1'b0, OFS_IRQ_MASK, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 8'h20, 32'h0);
      chk({31'h0, err}, 32'h1);
      for (int i = 0; i < 8; i++) lvl[i] = $urandom_range(254, 1);
      lvl[0] = 0;
      lvl[7] = 255;
      for (int i = 0; i < 8; i++) levels[i*8 +: 8] <= 8'(lvl[i]);
      apb(1'b1, OFS_IRQ_MASK, 32'h7);
      apb(1'b1, OFS_POLARITY, 32'h80);
      for (int c = 0; c < 8; c++) begin
         conv(c);
         chk({31'h0, irq}, 32'h1);
         apb(1'b0, OFS_IRQ_STAT, 32'h0);
         chk(rd, 32'h3);
         apb(1'b0, OFS_IRQ_STAT, 32'h0);
         chk(rd, 32'h0);
         chk({31'h0, irq}, 32'h0);
      end
      apb(1'b1, OFS_RESULT, 32'h5A);
      apb(1'b0, OFS_RESULT, 32'h0);
      chk(rd, sar(lvl[7]));
      conv(5);
      apb(1'b1, OFS_CONTROL, 32'h15);
      apb(1'b0, OFS_IRQ_STAT, 32'h0);
      chk(rd, 32'h3);
      repeat (100) @(posedge clk);
      conv(5);
      apb(1'b1, OFS_POLARITY, 32'h0);
      apb(1'b0, OFS_IRQ_STAT, 32'h0);
      conv(1);
      apb(1'b0, OFS_IRQ_STAT, 32'h0);
      chk(rd, 32'h2);
      @(posedge clk);
      ext <= 1'b1;
      repeat (6) @(posedge clk);
      apb(1'b0, OFS_IRQ_STAT, 32'h0);
      chk(rd, 32'h5);
      apb(1'b1, OFS_POLARITY, 32'h1);
      @(posedge clk);
      ext <= 1'b0;
      repeat (6) @(posedge clk);
      apb(1'b0, OFS_IRQ_STAT, 32'h0);
      chk(rd, 32'h5);
      apb(1'b1, OFS_IRQ_MASK, 32'h0);
      conv(4);
      chk({31'h0, irq}, 32'h0);
      @(posedge clk);
      gin <= 8'($urandom);
      apb(1'b1, OFS_CONTROL, 32'h0B);
      apb(1'b1, OFS_GPIO_DIR, 32'hFF);
      apb(1'b1, OFS_GPIO_OUT, 32'hA5);
      repeat (2) @(posedge clk);
      chk({31'h0, ladder}, 32'h0);
      chk({24'h0, goe}, 32'hFF);
      chk({24'h0, gout}, 32'hA5);
      apb(1'b0, OFS_GPIO_IN, 32'h0);
      chk(rd, {24'h0, gin});
      apb(1'b1, OFS_CONTROL, 32'h1B);
      repeat (2) @(posedge clk);
      chk({31'h0, ladder}, 32'h1);
      chk({29'h0, chan}, 32'h3);
      chk({24'h0, goe}, 32'hF7);
      tally_and_finish();
   end
   initial begin
      repeat (60000) @(posedge clk);
      fails++;
      tally_and_finish();
   end
endmodule : tb_sar_adc_sequencer
